// ---- hdl/lpi_pkg.sv ----
// Constants for the LED power register port: bus address, register map,
// field positions, reset values and sampling parameters.
// Assumes a single system clock domain; SCL and SDA are sampled pins.
package lpi_pkg;
    localparam logic [6:0] DEV_ADDR        = 7'h76;
    localparam int         NUM_REGS        = 9;
    localparam logic [7:0] OFS_POWER       = 8'h00;
    localparam logic [7:0] OFS_BACKLIGHT   = 8'h01;
    localparam logic [7:0] OFS_DIMMING     = 8'h02;
    localparam logic [7:0] OFS_REG12       = 8'h03;
    localparam logic [7:0] OFS_REG3_BOOST  = 8'h04;
    localparam logic [7:0] OFS_MAIN_CUR    = 8'h05;
    localparam logic [7:0] OFS_SUB5_CUR    = 8'h06;
    localparam logic [7:0] OFS_SUB6_CUR    = 8'h07;
    localparam logic [7:0] OFS_SUB_LED7_ENABLE_CUR    = 8'h08;
    localparam logic [7:0] RST_POWER       = 8'h00;
    localparam logic [7:0] RST_BACKLIGHT   = 8'h00;
    localparam logic [7:0] RST_DIMMING     = 8'h26;
    localparam logic [7:0] RST_REG12       = 8'h6C;
    localparam logic [7:0] RST_REG3_BOOST  = 8'hBA;
    localparam logic [7:0] RST_CURRENT     = 8'h01;
    localparam int         BIT_SOFT_RESET  = 7;
    localparam int         BIT_BOOST_EN    = 6;
    localparam int         BIT_CHARGE      = 6;
    localparam logic [7:0] DIMMING_MASK    = 8'hFB;
    localparam logic [7:0] REG12_MASK      = 8'hEF;
    localparam int         SYNC_STAGES     = 2;
endpackage : lpi_pkg

// ---- hdl/lpi_sync.sv ----
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
module lpi_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output var  logic dout
);
    logic meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_r <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : lpi_sync
`default_nettype wire

// ---- hdl/lpi_top.sv ----
// Two-wire slave port with the first register bank of the LED power device.
// Assumes SCL and SDA arrive as pin levels, slow against the 125 MHz SYS_CLK.
`timescale 1ns/10ps
`default_nettype none
module lpi_top (
    input  wire logic       SYS_CLK,
    input  wire logic       RESETN,
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output var  logic       SDA_O,
    output var  logic       SDA_OE_N,
    output var  logic       CHARGE_INDICATOR_OUT_O,
    output var  logic       CHARGE_INDICATOR_OUT_OE_N,
    output var  logic [7:0] POWER_ONOFF_CONTROL,
    output var  logic [7:0] BACKLIGHT_ONOFF_CONTROL,
    output var  logic [7:0] DIMMING_SIGNAL_CONTROL,
    output var  logic [7:0] REGULATOR12_VOLTAGE,
    output var  logic [7:0] REGULATOR3_BOOST_VOLTAGE,
    output var  logic [7:0] MAIN_WHITE_CURRENT,
    output var  logic [7:0] SUB5_WHITE_CURRENT,
    output var  logic [7:0] SUB6_WHITE_CURRENT,
    output var  logic [7:0] SUB_LED7_ENABLE_WHITE_CURRENT,
    output var  logic       BOOST_ENABLE
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_PTR, ST_WDATA, ST_RDATA, ST_MACK
    } lpi_state_t;

    typedef struct packed {
        lpi_state_t state;
        logic [2:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic       rw;
        logic       ptr_done;
        logic       drive_low;
        logic       scl_d;
        logic       sda_d;
        logic       byte_done;
        logic [8:0][7:0] regs;
    } lpi_st_t;

    lpi_st_t    st_r;
    lpi_st_t    st_nxt;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic [7:0] rd_byte;
    logic [7:0] wr_mask;

    lpi_sync #(.RESET_VAL(1'b1)) u_scl_sync (
        .clk    (SYS_CLK),
        .resetn (RESETN),
        .din    (SCL_I),
        .dout   (scl_s)
    );

    lpi_sync #(.RESET_VAL(1'b1)) u_sda_sync (
        .clk    (SYS_CLK),
        .resetn (RESETN),
        .din    (SDA_I),
        .dout   (sda_s)
    );

    // Edge and bus condition decode on the synchronised lines.
    assign scl_rise   = scl_s & ~st_r.scl_d;
    assign scl_fall   = ~scl_s & st_r.scl_d;
    assign start_cond = scl_s & st_r.scl_d & st_r.sda_d & ~sda_s;
    assign stop_cond  = scl_s & st_r.scl_d & ~st_r.sda_d & sda_s;

    // Read data for the current pointer; unmapped pointers read zero.
    always_comb begin
        rd_byte = 8'h00;
        if (st_r.ptr < 8'(lpi_pkg::NUM_REGS)) begin
            rd_byte = st_r.regs[st_r.ptr[3:0]];
        end
    end

    // Writable bits per register; don't-care bits are written as zero.
    always_comb begin
        wr_mask = 8'hFF;
        if (st_r.ptr == lpi_pkg::OFS_DIMMING) begin
            wr_mask = lpi_pkg::DIMMING_MASK;
        end else if (st_r.ptr == lpi_pkg::OFS_REG12) begin
            wr_mask = lpi_pkg::REG12_MASK;
        end
    end

    // Protocol engine and register bank next-state logic.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.scl_d = scl_s;
        st_nxt.sda_d = sda_s;
        if (start_cond) begin
            st_nxt.state     = ST_ADDR;
            st_nxt.bitcnt    = 3'd0;
            st_nxt.drive_low = 1'b0;
            st_nxt.ptr_done  = 1'b0;
            st_nxt.byte_done = 1'b0;
        end else if (stop_cond) begin
            st_nxt.state     = ST_IDLE;
            st_nxt.drive_low = 1'b0;
        end else begin
            case (st_r.state)
                ST_IDLE: begin
                    st_nxt.drive_low = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    // Sample one bit per rising SCL edge; the eighth rise marks a full byte.
                    if (scl_rise) begin
                        st_nxt.shift  = {st_r.shift[6:0], sda_s};
                        st_nxt.bitcnt = st_r.bitcnt + 3'd1;
                        if (st_r.bitcnt == 3'd7) begin
                            st_nxt.byte_done = 1'b1;
                        end
                    end
                    // The SCL fall that closes a start must not count as a byte end.
                    if (scl_fall && st_r.byte_done) begin
                        // Byte complete after eight rises: act on falling edge.
                        st_nxt.byte_done = 1'b0;
                        if (st_r.state == ST_ADDR) begin
                            if (st_r.shift[7:1] == lpi_pkg::DEV_ADDR) begin
                                st_nxt.rw        = st_r.shift[0];
                                st_nxt.drive_low = 1'b1;
                                st_nxt.state     = ST_ACK;
                            end else begin
                                st_nxt.state = ST_IDLE;
                            end
                        end else if (st_r.state == ST_PTR) begin
                            st_nxt.ptr       = st_r.shift;
                            st_nxt.ptr_done  = 1'b1;
                            st_nxt.drive_low = 1'b1;
                            st_nxt.state     = ST_ACK;
                        end else begin
                            for (int i = 0; i < lpi_pkg::NUM_REGS; i++) begin
                                if (st_r.ptr == 8'(i)) begin
                                    st_nxt.regs[i] = st_r.shift & wr_mask;
                                end
                            end
                            st_nxt.ptr       = st_r.ptr + 8'd1;
                            st_nxt.drive_low = 1'b1;
                            st_nxt.state     = ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    // Hold the acknowledge through the ninth pulse, then release or load data.
                    if (scl_fall) begin
                        st_nxt.bitcnt    = 3'd0;
                        st_nxt.drive_low = 1'b0;
                        if (st_r.rw) begin
                            st_nxt.state     = ST_RDATA;
                            st_nxt.shift     = rd_byte;
                            st_nxt.drive_low = ~rd_byte[7];
                        end else begin
                            st_nxt.state = st_r.ptr_done ? ST_WDATA : ST_PTR;
                        end
                    end
                end
                ST_RDATA: begin
                    // Shift a byte out, changing SDA only while SCL is low.
                    if (scl_fall) begin
                        st_nxt.bitcnt = st_r.bitcnt + 3'd1;
                        if (st_r.bitcnt == 3'd7) begin
                            st_nxt.drive_low = 1'b0;
                            st_nxt.state     = ST_MACK;
                        end else begin
                            st_nxt.shift     = {st_r.shift[6:0], 1'b0};
                            st_nxt.drive_low = ~st_r.shift[6];
                        end
                    end
                end
                ST_MACK: begin
                    // Master acknowledge continues; no acknowledge ends the read.
                    if (scl_rise) begin
                        if (sda_s) begin
                            st_nxt.state = ST_IDLE;
                        end else begin
                            st_nxt.ptr = st_r.ptr + 8'd1;
                        end
                    end
                    if (scl_fall) begin
                        st_nxt.bitcnt    = 3'd0;
                        st_nxt.state     = ST_RDATA;
                        st_nxt.shift     = rd_byte;
                        st_nxt.drive_low = ~rd_byte[7];
                    end
                end
                default: begin
                    st_nxt.state = ST_IDLE;
                end
            endcase
        end
        // Soft reset bit restores every default and clears itself.
        if (st_r.regs[0][lpi_pkg::BIT_SOFT_RESET]) begin
            st_nxt.regs[0] = lpi_pkg::RST_POWER;
            st_nxt.regs[1] = lpi_pkg::RST_BACKLIGHT;
            st_nxt.regs[2] = lpi_pkg::RST_DIMMING;
            st_nxt.regs[3] = lpi_pkg::RST_REG12;
            st_nxt.regs[4] = lpi_pkg::RST_REG3_BOOST;
            for (int i = 5; i < lpi_pkg::NUM_REGS; i++) begin
                st_nxt.regs[i] = lpi_pkg::RST_CURRENT;
            end
        end
    end

    // State register with register defaults at reset.
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            st_r.state     <= ST_IDLE;
            st_r.bitcnt    <= 3'd0;
            st_r.shift     <= 8'h00;
            st_r.ptr       <= 8'h00;
            st_r.rw        <= 1'b0;
            st_r.ptr_done  <= 1'b0;
            st_r.drive_low <= 1'b0;
            st_r.byte_done <= 1'b0;
            st_r.scl_d     <= 1'b1;
            st_r.sda_d     <= 1'b1;
            st_r.regs[0]   <= lpi_pkg::RST_POWER;
            st_r.regs[1]   <= lpi_pkg::RST_BACKLIGHT;
            st_r.regs[2]   <= lpi_pkg::RST_DIMMING;
            st_r.regs[3]   <= lpi_pkg::RST_REG12;
            st_r.regs[4]   <= lpi_pkg::RST_REG3_BOOST;
            for (int i = 5; i < lpi_pkg::NUM_REGS; i++) begin
                st_r.regs[i] <= lpi_pkg::RST_CURRENT;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // Output flops; codes pass raw, the analog sink scales 0.1 mA per step.
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            SDA_O                     <= 1'b0;
            SDA_OE_N                  <= 1'b1;
            CHARGE_INDICATOR_OUT_O    <= 1'b0;
            CHARGE_INDICATOR_OUT_OE_N <= 1'b1;
            POWER_ONOFF_CONTROL       <= lpi_pkg::RST_POWER;
            BACKLIGHT_ONOFF_CONTROL   <= lpi_pkg::RST_BACKLIGHT;
            DIMMING_SIGNAL_CONTROL    <= lpi_pkg::RST_DIMMING;
            REGULATOR12_VOLTAGE       <= lpi_pkg::RST_REG12;
            REGULATOR3_BOOST_VOLTAGE  <= lpi_pkg::RST_REG3_BOOST;
            MAIN_WHITE_CURRENT        <= lpi_pkg::RST_CURRENT;
            SUB5_WHITE_CURRENT        <= lpi_pkg::RST_CURRENT;
            SUB6_WHITE_CURRENT        <= lpi_pkg::RST_CURRENT;
            SUB_LED7_ENABLE_WHITE_CURRENT        <= lpi_pkg::RST_CURRENT;
            BOOST_ENABLE              <= 1'b0;
        end else begin
            SDA_O                     <= 1'b0;
            SDA_OE_N                  <= ~st_nxt.drive_low;
            CHARGE_INDICATOR_OUT_O    <= 1'b0;
            CHARGE_INDICATOR_OUT_OE_N <= ~st_nxt.regs[2][lpi_pkg::BIT_CHARGE];
            POWER_ONOFF_CONTROL       <= st_nxt.regs[0];
            BACKLIGHT_ONOFF_CONTROL   <= st_nxt.regs[1];
            DIMMING_SIGNAL_CONTROL    <= st_nxt.regs[2];
            REGULATOR12_VOLTAGE       <= st_nxt.regs[3];
            REGULATOR3_BOOST_VOLTAGE  <= st_nxt.regs[4];
            MAIN_WHITE_CURRENT        <= st_nxt.regs[5];
            SUB5_WHITE_CURRENT        <= st_nxt.regs[6];
            SUB6_WHITE_CURRENT        <= st_nxt.regs[7];
            SUB_LED7_ENABLE_WHITE_CURRENT        <= st_nxt.regs[8];
            BOOST_ENABLE              <= st_nxt.regs[0][lpi_pkg::BIT_BOOST_EN];
        end
    end

    // Named sequences for multi-step checks.
    sequence s_stop_seen;
        stop_cond;
    endsequence

    a_charge_pin_low: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.regs[2][lpi_pkg::BIT_CHARGE] |-> ##0 !CHARGE_INDICATOR_OUT_OE_N)
        else $error("charge indicator not driven low");
    a_charge_pin_rel: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !st_r.regs[2][lpi_pkg::BIT_CHARGE] |-> CHARGE_INDICATOR_OUT_OE_N)
        else $error("charge indicator not released");
    a_stop_idle: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        s_stop_seen |=> st_r.state == ST_IDLE ##1 SDA_OE_N)
        else $error("stop did not return to idle");
    a_start_addr: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        start_cond |=> st_r.state == ST_ADDR && st_r.bitcnt == 3'd0)
        else $error("start not detected");
    a_idle_released: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.state == ST_IDLE && $past(st_r.state) == ST_IDLE |-> SDA_OE_N)
        else $error("sda driven while idle");
    a_ack_hold: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.state == ST_ACK && scl_s |-> !SDA_OE_N)
        else $error("ack released during high phase");
    a_sda_stable: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        scl_s && st_r.scl_d && !start_cond && !stop_cond |=> $stable(SDA_OE_N))
        else $error("sda drive changed while scl high");
    a_boost_follow: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !st_r.regs[0][lpi_pkg::BIT_BOOST_EN] |-> !BOOST_ENABLE)
        else $error("boost enabled while bit clear");

    sequence s_back_idle;
        st_r.state == ST_IDLE ##1 SDA_OE_N;
    endsequence
    a_addr_ack: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.state == ST_ADDR && scl_fall && st_r.byte_done && st_r.shift[7:1] == lpi_pkg::DEV_ADDR |=> !SDA_OE_N)
        else $error("own address not acknowledged");
    a_foreign_silent: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.state == ST_ADDR && scl_fall && st_r.byte_done && st_r.shift[7:1] != lpi_pkg::DEV_ADDR |=> s_back_idle)
        else $error("foreign address not ignored");
    a_nack_ends: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.state == ST_MACK && scl_rise && sda_s |=> s_back_idle)
        else $error("read not ended on missing acknowledge");
    a_byte_written: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.state == ST_WDATA && scl_fall && st_r.byte_done && st_r.ptr == lpi_pkg::OFS_MAIN_CUR |=> MAIN_WHITE_CURRENT == $past(st_r.shift))
        else $error("current code write lost");
    a_soft_defaults: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        st_r.regs[0][lpi_pkg::BIT_SOFT_RESET] |=> POWER_ONOFF_CONTROL == lpi_pkg::RST_POWER && MAIN_WHITE_CURRENT == lpi_pkg::RST_CURRENT)
        else $error("soft reset did not restore defaults");
endmodule : lpi_top
`default_nettype wire

// ---- tb/lpi_master_model.sv ----
// Behavioural two-wire bus master that drives the register port's pins.
// Assumes a pull-up on the data line; the bench resolves the wire level.
`timescale 1ns/10ps
`default_nettype none
module lpi_master_model #(
    parameter int HALF = 10
) (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    // Both lines rest released until the first transfer.
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // Waits a number of falling clock edges, the bench's drive edge.
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Moves one bit; data changes only while the clock is low, and a low is seen only if low at both the middle and the end of the high phase.
    task automatic xfer_bit(input logic b, output logic s);
        logic v;
        tick(HALF / 2);
        sda_low = ~b;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF / 2);
        v = sda;
        tick(HALF / 2);
        s = v | sda;
        scl = 1'b0;
    endtask : xfer_bit

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        tick(HALF / 2);
        sda_low = 1'b0;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask : start

    // Stop: data rises while the clock is high, leaving both lines released.
    task automatic stop();
        tick(HALF / 2);
        sda_low = 1'b1;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask : stop

    // Sends a byte most significant bit first, then releases the line for the ninth pulse.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], s);
        end
        xfer_bit(1'b1, s);
        ack = ~s;
    endtask : wr_byte

    // Reads a byte; acknowledges it unless it is the last one, and returns the ninth-slot level.
    task automatic rd_byte(input logic last, output logic [7:0] d, output logic lvl);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, s);
            d[i] = s;
        end
        xfer_bit(last, lvl);
    endtask : rd_byte
endmodule : lpi_master_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the register port, driven through a bus master model.
// Assumes the data line has a pull-up; the bench resolves the open-drain wire.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       sys_clk;
    logic       resetn;
    logic       scl;
    logic       m_low;
    wire  logic sda;
    logic       sda_o;
    logic       sda_oe_n;
    logic       chg_o;
    logic       chg_oe_n;
    logic       boost;
    logic [7:0] regs [9];
    logic [7:0] rstv [9];
    logic [7:0] msk  [9];
    logic [7:0] expv [9];
    int         miscompares;
    int         num_checks;

    // Wire level: pulled high unless either party pulls it low.
    assign sda = ~(m_low | ~sda_oe_n);

    // Clock of 125 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    lpi_master_model #(.HALF(10)) master (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(m_low));

    lpi_top uut (
        .SYS_CLK                  (sys_clk),
        .RESETN                   (resetn),
        .SCL_I                    (scl),
        .SDA_I                    (sda),
        .SDA_O                    (sda_o),
        .SDA_OE_N                 (sda_oe_n),
        .CHARGE_INDICATOR_OUT_O   (chg_o),
        .CHARGE_INDICATOR_OUT_OE_N(chg_oe_n),
        .POWER_ONOFF_CONTROL      (regs[0]),
        .BACKLIGHT_ONOFF_CONTROL  (regs[1]),
        .DIMMING_SIGNAL_CONTROL   (regs[2]),
        .REGULATOR12_VOLTAGE      (regs[3]),
        .REGULATOR3_BOOST_VOLTAGE (regs[4]),
        .MAIN_WHITE_CURRENT       (regs[5]),
        .SUB5_WHITE_CURRENT       (regs[6]),
        .SUB6_WHITE_CURRENT       (regs[7]),
        .SUB_LED7_ENABLE_WHITE_CURRENT       (regs[8]),
        .BOOST_ENABLE             (boost)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test();
        $display("TB: %0d checks, %0d miscompares", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Compares a seen value with the expected one and counts both.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Write transfer: address byte, pointer, then n data bytes from expv.
    task automatic write_seq(input logic [7:0] ptr, input int n, input logic [6:0] addr, input logic exp_ack);
        logic a;
        master.start();
        master.wr_byte({addr, 1'b0}, a);
        check({7'h0, a}, {7'h0, exp_ack});
        master.wr_byte(ptr, a);
        check({7'h0, a}, {7'h0, exp_ack});
        for (int i = 0; i < n; i++) begin
            master.wr_byte(expv[i], a);
            check({7'h0, a}, {7'h0, exp_ack});
        end
        master.stop();
    endtask : write_seq

    // Sets the pointer, repeats the start, reads n bytes and compares them with expv.
    task automatic read_chk(input logic [7:0] ptr, input int n);
        logic       a;
        logic [7:0] d;
        master.start();
        master.wr_byte({lpi_pkg::DEV_ADDR, 1'b0}, a);
        master.wr_byte(ptr, a);
        master.start();
        master.wr_byte({lpi_pkg::DEV_ADDR, 1'b1}, a);
        check({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            master.rd_byte(i == n - 1, d, a);
            check(d, expv[i]);
        end
        check({7'h0, a}, 8'h01);
        master.stop();
        check({7'h0, sda_oe_n}, 8'h01);
    endtask : read_chk

    // Main sequence of register scenarios.
    initial begin
        miscompares = 0;
        num_checks  = 0;
        resetn      = 1'b0;
        rstv = '{lpi_pkg::RST_POWER, lpi_pkg::RST_BACKLIGHT, lpi_pkg::RST_DIMMING, lpi_pkg::RST_REG12,
                 lpi_pkg::RST_REG3_BOOST, lpi_pkg::RST_CURRENT, lpi_pkg::RST_CURRENT, lpi_pkg::RST_CURRENT,
                 lpi_pkg::RST_CURRENT};
        msk  = '{8'hFF, 8'hFF, lpi_pkg::DIMMING_MASK, lpi_pkg::REG12_MASK, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        repeat (4) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        // Defaults at the pins and over the bus.
        for (int i = 0; i < 9; i++) check(regs[i], rstv[i]);
        check({7'h0, chg_oe_n}, 8'h01);
        check({7'h0, sda_oe_n}, 8'h01);
        check({7'h0, sda_o}, 8'h00);
        expv = rstv;
        read_chk(8'h00, 9);
        // Burst write of the whole bank with boundary current codes, then read back.
        expv = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h45, 8'hFF, 8'h00, 8'hA5, 8'h5A};
        write_seq(8'h00, 9, lpi_pkg::DEV_ADDR, 1'b1);
        for (int i = 0; i < 9; i++) expv[i] = expv[i] & msk[i];
        for (int i = 0; i < 9; i++) check(regs[i], expv[i]);
        check({7'h0, boost}, 8'h01);
        check({7'h0, chg_oe_n}, 8'h00);
        check({7'h0, chg_o}, 8'h00);
        read_chk(8'h00, 9);
        // A foreign address is neither acknowledged nor written.
        expv[0] = 8'h33;
        write_seq(8'h05, 1, lpi_pkg::DEV_ADDR ^ 7'h01, 1'b0);
        check(regs[5], 8'hFF);
        // Clearing the charge bit releases the pin; clearing the boost bit shuts it down.
        expv[0] = 8'h00;
        write_seq(8'h02, 1, lpi_pkg::DEV_ADDR, 1'b1);
        check({7'h0, chg_oe_n}, 8'h01);
        write_seq(8'h00, 1, lpi_pkg::DEV_ADDR, 1'b1);
        check({7'h0, boost}, 8'h00);
        // An unmapped pointer takes writes silently and reads as zero.
        expv[0] = 8'h77;
        write_seq(8'h09, 1, lpi_pkg::DEV_ADDR, 1'b1);
        expv[0] = 8'h00;
        read_chk(8'h09, 1);
        // Soft reset bit restores every default.
        expv[0] = 8'h80;
        write_seq(8'h00, 1, lpi_pkg::DEV_ADDR, 1'b1);
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 9; i++) check(regs[i], rstv[i]);
        // A reset in mid-run restores the defaults as well.
        expv[0] = 8'hAA;
        write_seq(8'h05, 1, lpi_pkg::DEV_ADDR, 1'b1);
        check(regs[5], 8'hAA);
        resetn = 1'b0;
        repeat (4) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        check(regs[5], lpi_pkg::RST_CURRENT);
        expv = rstv;
        read_chk(8'h00, 9);
        end_of_test();
    end

    // Cuts a hung run short and reports it as a mismatch.
    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
